// ---- ibr_consts.svh ----
// constants of the board information register bank: indexes, slots, masks, result codes
`ifndef IBR_CONSTS_SVH
`define IBR_CONSTS_SVH

// parameter indexes seen by software (decimal 2000 .. 2300)
`define IBR_IDX_BOARD_TYPE 16'h07d0
`define IBR_IDX_HW_REV 16'h07da
`define IBR_IDX_EXP_REV 16'h07db
`define IBR_IDX_PROD_DATE 16'h07e4
`define IBR_IDX_SERIAL 16'h07ee
`define IBR_IDX_MAX_RATE 16'h0834
`define IBR_IDX_MEM_BYTES 16'h083e
`define IBR_IDX_OPTIONS 16'h0848
`define IBR_IDX_IRQ_LINE 16'h08fc

// rom word slots, in the order the loader fetches them
`define IBR_ROM_WORDS 8
`define IBR_ROM_LAST 3'h7
`define IBR_SLOT_TYPE 3'h0
`define IBR_SLOT_HW_REV 3'h1
`define IBR_SLOT_EXP_REV 3'h2
`define IBR_SLOT_DATE 3'h3
`define IBR_SLOT_SERIAL 3'h4
`define IBR_SLOT_RATE 3'h5
`define IBR_SLOT_MEM 3'h6
`define IBR_SLOT_OPTIONS 3'h7

// field layout of the hardware revision word
`define IBR_HWREV_BASE_MSB 15
`define IBR_HWREV_BASE_LSB 8
`define IBR_HWREV_MOD_MSB 7
`define IBR_HWREV_MOD_LSB 0

// production date: year in the top half, month in the low byte, byte 1 unused
`define IBR_DATE_KEEP 32'hffff_00ff

// installed option masks
`define IBR_OPT_MULTI_REPLAY 32'h0000_0001
`define IBR_OPT_DIGITAL_OUTPUTS 32'h0000_0002
`define IBR_OPT_GATED_REPLAY 32'h0000_0020
`define IBR_OPT_SYNCHRONIZATION 32'h0000_0200
`define IBR_OPT_TIMESTAMP 32'h0000_0400
`define IBR_OPT_HUB_MODULE 32'h0000_0800
`define IBR_OPT_EXTRA_IO 32'h0000_2000
`define IBR_OPT_AMPLIFIER_CAL 32'h0000_4000
`define IBR_OPT_DEFINED 32'h0000_6e23

// initialization result codes, zero means success
`define IBR_ERR_OK 8'h00
`define IBR_ERR_NOT_INIT 8'h01
`define IBR_ERR_BAD_TYPE 8'h02
`define IBR_ERR_HUB_NO_SYNC 8'h03

// reset values
`define IBR_WORD_RST 32'h0000_0000
`define IBR_IRQ_RST 8'h00

`endif

// ---- ibr_info_bank.sv ----
// board information register bank with rom load and parameter read port
`timescale 1ns/10ps
`include "ibr_consts.svh"
module ibr_info_bank #(
   // model codes, values are arbitrary
   parameter ibr_pkg::ibr_word_t MODEL_A_CODE = 32'h0000_0a01,
   parameter ibr_pkg::ibr_word_t MODEL_B_CODE = 32'h0000_0a02
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // initialization
   input wire logic init_req_i,
   output logic init_busy_o,
   output logic init_done_o,
   output ibr_pkg::ibr_code_t init_result_o,
   // parameter access port
   input wire logic param_rd_i,
   input wire logic param_wr_i,
   input wire logic [15:0] param_idx_i,
   output logic param_ack_o,
   output logic param_err_o,
   output ibr_pkg::ibr_word_t param_rdata_o,
   // on-board rom
   output logic rom_rd_o,
   output ibr_pkg::ibr_slot_t rom_addr_o,
   input wire ibr_pkg::ibr_word_t rom_data_i,
   // interrupt line assigned at enumeration
   input wire logic [7:0] irq_line_i
);
   import ibr_pkg::*;

   ibr_bank_t st_r;
   ibr_bank_t st_nxt;
   logic load_start;
   logic load_done;
   logic word_vld;
   ibr_slot_t word_idx;
   logic init_take;
   logic bank_ok;
   ibr_code_t check_code;
   ibr_word_t opt_w;
   ibr_word_t rd_word;
   logic rd_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // rom sequencer
   ibr_rom_loader u_loader (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .start_i(load_start),
      .done_o(load_done),
      .rom_rd_o(rom_rd_o),
      .rom_addr_o(rom_addr_o),
      .word_vld_o(word_vld),
      .word_idx_o(word_idx)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // requests while a load runs are dropped, a new load needs idle or ready
   assign init_take = init_req_i && ((st_r.fsm == IBR_IDLE) || (st_r.fsm == IBR_READY));
   assign load_start = init_take;
   assign bank_ok = (st_r.fsm == IBR_READY) && (st_r.result == `IBR_ERR_OK);
   assign opt_w = st_r.info[`IBR_SLOT_OPTIONS];

   // consistency check of the loaded words
   always_comb begin
      check_code = `IBR_ERR_OK;
      if ((st_r.info[`IBR_SLOT_TYPE] != MODEL_A_CODE) && (st_r.info[`IBR_SLOT_TYPE] != MODEL_B_CODE)) begin
         check_code = `IBR_ERR_BAD_TYPE;
      end else if (((opt_w & `IBR_OPT_HUB_MODULE) != 32'h0000_0000)
                   && ((opt_w & `IBR_OPT_SYNCHRONIZATION) == 32'h0000_0000)) begin
         check_code = `IBR_ERR_HUB_NO_SYNC;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // index decode: an if chain, unknown indexes miss
   always_comb begin
      rd_word = `IBR_WORD_RST;
      rd_hit = 1'b1;
      if (param_idx_i == `IBR_IDX_BOARD_TYPE) begin
         rd_word = st_r.info[`IBR_SLOT_TYPE];
      end else if (param_idx_i == `IBR_IDX_HW_REV) begin
         rd_word = st_r.info[`IBR_SLOT_HW_REV];
      end else if (param_idx_i == `IBR_IDX_EXP_REV) begin
         rd_word = st_r.info[`IBR_SLOT_EXP_REV];
      end else if (param_idx_i == `IBR_IDX_PROD_DATE) begin
         rd_word = st_r.info[`IBR_SLOT_DATE];
      end else if (param_idx_i == `IBR_IDX_SERIAL) begin
         rd_word = st_r.info[`IBR_SLOT_SERIAL];
      end else if (param_idx_i == `IBR_IDX_MAX_RATE) begin
         rd_word = st_r.info[`IBR_SLOT_RATE];
      end else if (param_idx_i == `IBR_IDX_MEM_BYTES) begin
         rd_word = st_r.info[`IBR_SLOT_MEM];
      end else if (param_idx_i == `IBR_IDX_OPTIONS) begin
         rd_word = opt_w;
      end else if (param_idx_i == `IBR_IDX_IRQ_LINE) begin
         rd_word = {24'h00_0000, st_r.irq};
      end else begin
         rd_hit = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // next state of the whole bank
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      st_nxt.ack = 1'b0;
      st_nxt.err = 1'b0;
      st_nxt.irq = irq_line_i;
      case (st_r.fsm)
         IBR_IDLE: begin
            if (init_take) begin
               st_nxt.fsm = IBR_LOAD;
            end
         end
         IBR_LOAD: begin
            // the rom is the only source of the information words
            if (word_vld) begin
               if (word_idx == `IBR_SLOT_DATE) begin
                  st_nxt.info[word_idx] = rom_data_i & `IBR_DATE_KEEP;
               end else if (word_idx == `IBR_SLOT_OPTIONS) begin
                  st_nxt.info[word_idx] = rom_data_i & `IBR_OPT_DEFINED;
               end else begin
                  st_nxt.info[word_idx] = rom_data_i;
               end
            end
            if (load_done) begin
               st_nxt.fsm = IBR_CHECK;
            end
         end
         IBR_CHECK: begin
            st_nxt.result = check_code;
            st_nxt.done = 1'b1;
            st_nxt.fsm = IBR_READY;
         end
         IBR_READY: begin
            // a reload hides the old values until it has been checked again
            if (init_take) begin
               st_nxt.fsm = IBR_LOAD;
               st_nxt.result = `IBR_ERR_NOT_INIT;
            end
         end
         default: begin
            st_nxt.fsm = IBR_IDLE;
         end
      endcase
      // parameter port: writes are answered with an error and change nothing
      if (param_rd_i || param_wr_i) begin
         st_nxt.ack = 1'b1;
         st_nxt.rdata = `IBR_WORD_RST;
         if (param_wr_i) begin
            st_nxt.err = 1'b1;
         end else if (!bank_ok || !rd_hit) begin
            st_nxt.err = 1'b1;
         end else begin
            st_nxt.rdata = rd_word;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_r.fsm <= IBR_IDLE;
         st_r.info <= '0;
         st_r.irq <= `IBR_IRQ_RST;
         st_r.result <= `IBR_ERR_NOT_INIT;
         st_r.done <= 1'b0;
         st_r.ack <= 1'b0;
         st_r.err <= 1'b0;
         st_r.rdata <= `IBR_WORD_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign init_busy_o = (st_r.fsm == IBR_LOAD) || (st_r.fsm == IBR_CHECK);
   assign init_done_o = st_r.done;
   assign init_result_o = st_r.result;
   assign param_ack_o = st_r.ack;
   assign param_err_o = st_r.err;
   assign param_rdata_o = st_r.rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // checks on the bank's own behaviour
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   logic rd_ok;
   assign rd_ok = param_rd_i && !param_wr_i && bank_ok;

   a_write_refused: assert property (
      param_wr_i |=> param_ack_o && param_err_o && (param_rdata_o == 32'h0000_0000))
      else $error("write to the bank was not refused");
   a_write_keeps_info: assert property (
      (param_wr_i && (st_r.fsm == IBR_READY) && !init_req_i) |=> $stable(st_r.info))
      else $error("write changed stored information");
   // counted from the cycle after the request, so a new request on a done cycle cannot trip it
   a_init_done_time: assert property (
      init_take |=> !init_done_o [*8] ##1 !init_done_o [*2] ##1 init_done_o)
      else $error("initialization did not end after eleven cycles");
   a_result_zero_ok: assert property (
      init_done_o |-> ((init_result_o == 8'h00) == ($past(check_code) == 8'h00)))
      else $error("initialization result does not match the check");
   a_type_model: assert property ((rd_ok && (param_idx_i == `IBR_IDX_BOARD_TYPE))
      |=> !param_err_o && ((param_rdata_o == MODEL_A_CODE) || (param_rdata_o == MODEL_B_CODE)))
      else $error("board type read is not a model code");
   a_hwrev_fields: assert property ((rd_ok && (param_idx_i == `IBR_IDX_HW_REV))
      |=> (param_rdata_o[15:8] == $past(st_r.info[1][15:8])) && (param_rdata_o[7:0] == $past(st_r.info[1][7:0])))
      else $error("hardware revision fields misplaced");
   a_date_byte_zero: assert property ((rd_ok && (param_idx_i == `IBR_IDX_PROD_DATE))
      |=> param_rdata_o[15:8] == 8'h00)
      else $error("unused date byte is not zero");
   a_rate_word: assert property ((rd_ok && (param_idx_i == `IBR_IDX_MAX_RATE))
      |=> param_rdata_o == $past(st_r.info[5]))
      else $error("sample rate read wrong");
   a_mem_word: assert property ((rd_ok && (param_idx_i == `IBR_IDX_MEM_BYTES))
      |=> param_rdata_o == $past(st_r.info[6]))
      else $error("memory size read wrong");
   a_hub_implies_sync: assert property (bank_ok |-> !(opt_w[11] && !opt_w[9]))
      else $error("hub flag without synchronization flag");
   a_opt_undefined: assert property (bank_ok |-> ((opt_w & ~`IBR_OPT_DEFINED) == 32'h0000_0000))
      else $error("undefined option bit set");
   a_irq_current: assert property ((rd_ok && (param_idx_i == `IBR_IDX_IRQ_LINE))
      |=> param_rdata_o == {24'h00_0000, $past(irq_line_i, 2)})
      else $error("interrupt line read is stale");
   a_read_refused: assert property (
      (param_rd_i && !param_wr_i && !bank_ok) |=> param_ack_o && param_err_o)
      else $error("read before good initialization not refused");

   c_init_ok: cover property (init_done_o && (init_result_o == 8'h00));
   c_write_try: cover property (param_wr_i ##1 param_ack_o);
   c_type_read: cover property (rd_ok && (param_idx_i == `IBR_IDX_BOARD_TYPE));
   c_hub_error: cover property (init_done_o && (init_result_o == `IBR_ERR_HUB_NO_SYNC));
endmodule : ibr_info_bank

// ---- ibr_pkg.sv ----
// types of the board information register bank
`include "ibr_consts.svh"
package ibr_pkg;
   typedef logic [31:0] ibr_word_t;
   typedef logic [7:0] ibr_code_t;
   typedef logic [2:0] ibr_slot_t;
   // gray-coded along idle, load, check, ready
   typedef enum logic [1:0] {
      IBR_IDLE = 2'b00,
      IBR_LOAD = 2'b01,
      IBR_CHECK = 2'b11,
      IBR_READY = 2'b10
   } ibr_fsm_t;
   typedef struct packed {
      ibr_fsm_t fsm;
      ibr_word_t [`IBR_ROM_WORDS-1:0] info;
      logic [7:0] irq;
      ibr_code_t result;
      logic done;
      logic ack;
      logic err;
      ibr_word_t rdata;
   } ibr_bank_t;
   typedef struct packed {
      logic busy;
      ibr_slot_t addr;
      logic vld;
      ibr_slot_t vidx;
      logic done;
   } ibr_load_t;
endpackage : ibr_pkg

// ---- ibr_rom_loader.sv ----
// sequencer that reads every information word from the on-board rom once
`timescale 1ns/10ps
`include "ibr_consts.svh"
module ibr_rom_loader (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // control
   input wire logic start_i,
   output logic done_o,
   // rom side, data returns one cycle after the read
   output logic rom_rd_o,
   output ibr_pkg::ibr_slot_t rom_addr_o,
   // captured word
   output logic word_vld_o,
   output ibr_pkg::ibr_slot_t word_idx_o
);
   import ibr_pkg::*;

   ibr_load_t ld_r;
   ibr_load_t ld_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // next state: one read per cycle, last slot ends the run
   always_comb begin
      ld_nxt = ld_r;
      ld_nxt.vld = ld_r.busy;
      ld_nxt.vidx = ld_r.addr;
      ld_nxt.done = ld_r.busy && (ld_r.addr == `IBR_ROM_LAST);
      if (ld_r.busy) begin
         if (ld_r.addr == `IBR_ROM_LAST) begin
            ld_nxt.busy = 1'b0;
         end else begin
            ld_nxt.addr = ld_r.addr + 3'h1;
         end
      end else if (start_i) begin
         ld_nxt.busy = 1'b1;
         ld_nxt.addr = 3'h0;
      end
   end

   // state register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ld_r <= '0;
      end else begin
         ld_r <= ld_nxt;
      end
   end

   // outputs straight from the state
   assign rom_rd_o = ld_r.busy;
   assign rom_addr_o = ld_r.addr;
   assign word_vld_o = ld_r.vld;
   assign word_idx_o = ld_r.vidx;
   assign done_o = ld_r.done;
endmodule : ibr_rom_loader

// ---- tb_top.sv ----
// self-checking testbench of the board information register bank
`timescale 1ns/10ps
`include "ibr_consts.svh"
module tb_top;
   import ibr_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // model codes are arbitrary, handed to the bank as parameters
   localparam ibr_word_t CODE_A = 32'h0000_0a01;
   localparam ibr_word_t CODE_B = 32'h0000_0a02;
   // every defined option flag, built from the single masks
   localparam ibr_word_t OPT_ALL = `IBR_OPT_MULTI_REPLAY | `IBR_OPT_DIGITAL_OUTPUTS | `IBR_OPT_GATED_REPLAY |
      `IBR_OPT_SYNCHRONIZATION | `IBR_OPT_TIMESTAMP | `IBR_OPT_HUB_MODULE | `IBR_OPT_EXTRA_IO |
      `IBR_OPT_AMPLIFIER_CAL;
   logic core_clk_i;
   logic rst_i;
   logic init_req_i;
   logic init_busy_o;
   logic init_done_o;
   ibr_code_t init_result_o;
   logic param_rd_i;
   logic param_wr_i;
   logic [15:0] param_idx_i;
   logic param_ack_o;
   logic param_err_o;
   ibr_word_t param_rdata_o;
   logic rom_rd_o;
   ibr_slot_t rom_addr_o;
   ibr_word_t rom_data_i;
   logic [7:0] irq_line_i;
   ibr_word_t rom_img [`IBR_ROM_WORDS];
   int fail_count;
   int checks_done;
   ////////////////////////////////////////////////////////////////////////////
   // device under test
   ibr_info_bank #(.MODEL_A_CODE(CODE_A), .MODEL_B_CODE(CODE_B)) i_ibr_info_bank (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .init_req_i(init_req_i),
      .init_busy_o(init_busy_o),
      .init_done_o(init_done_o),
      .init_result_o(init_result_o),
      .param_rd_i(param_rd_i),
      .param_wr_i(param_wr_i),
      .param_idx_i(param_idx_i),
      .param_ack_o(param_ack_o),
      .param_err_o(param_err_o),
      .param_rdata_o(param_rdata_o),
      .rom_rd_o(rom_rd_o),
      .rom_addr_o(rom_addr_o),
      .rom_data_i(rom_data_i),
      .irq_line_i(irq_line_i)
   );
   // rom answers one cycle after the read; between reads it toggles so a stale word never passes as valid
   always @(posedge core_clk_i) begin
      if (rom_rd_o === 1'b1) begin
         rom_data_i <= rom_img[rom_addr_o];
      end else begin
         rom_data_i <= ~rom_data_i;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // compare and report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // closing report, also reached by the watchdog
   task automatic print_verdict();
      if (fail_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   // initialization: busy from cycle 1 with result not ready, done exactly in cycle 11
   task automatic run_init(input ibr_code_t exp_res);
      @(posedge core_clk_i);
      init_req_i <= 1'b1;
      @(posedge core_clk_i);
      init_req_i <= 1'b0;
      #1;
      chk(32'(init_busy_o), 32'h1);
      chk(32'(init_result_o), 32'(`IBR_ERR_NOT_INIT));
      chk(32'(rom_rd_o), 32'h1);
      chk(32'(rom_addr_o), 32'(`IBR_SLOT_TYPE));
      // a second request and a read while loading are both turned away
      @(posedge core_clk_i);
      init_req_i <= 1'b1;
      param_rd_i <= 1'b1;
      param_idx_i <= `IBR_IDX_SERIAL;
      @(posedge core_clk_i);
      init_req_i <= 1'b0;
      param_rd_i <= 1'b0;
      #1;
      chk(32'(param_ack_o), 32'h1);
      chk(32'(param_err_o), 32'h1);
      repeat (8) @(posedge core_clk_i);
      #1;
      chk(32'(init_done_o), 32'h1);
      chk(32'(init_busy_o), 32'h0);
      chk(32'(rom_rd_o), 32'h0);
      chk(32'(init_result_o), 32'(exp_res));
   endtask : run_init
   // one parameter access, answer looked at in the single ack cycle
   task automatic acc(input logic rd, input logic wr, input logic [15:0] idx, input logic err, input ibr_word_t data);
      @(posedge core_clk_i);
      param_rd_i <= rd;
      param_wr_i <= wr;
      param_idx_i <= idx;
      @(posedge core_clk_i);
      param_rd_i <= 1'b0;
      param_wr_i <= 1'b0;
      #1;
      chk(32'(param_ack_o), 32'h1);
      chk(32'(param_err_o), 32'(err));
      chk(param_rdata_o, data);
   endtask : acc
   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      #1;
      chk(32'(init_result_o), 32'(`IBR_ERR_NOT_INIT));
      chk(32'(init_busy_o), 32'h0);
      chk(32'(init_done_o), 32'h0);
      chk(32'(rom_rd_o), 32'h0);
      chk(32'(param_ack_o), 32'h0);
      acc(1'b1, 1'b0, `IBR_IDX_BOARD_TYPE, 1'b1, 32'h0000_0000);
   endtask : t_reset
   task automatic t_read_all();
      run_init(`IBR_ERR_OK);
      acc(1'b1, 1'b0, `IBR_IDX_BOARD_TYPE, 1'b0, CODE_A);
      acc(1'b1, 1'b0, `IBR_IDX_HW_REV, 1'b0, 32'h0000_3c5a);
      acc(1'b1, 1'b0, `IBR_IDX_EXP_REV, 1'b0, 32'h0000_0007);
      acc(1'b1, 1'b0, `IBR_IDX_PROD_DATE, 1'b0, 32'h07e2_0005);
      acc(1'b1, 1'b0, `IBR_IDX_SERIAL, 1'b0, 32'h0001_2345);
      acc(1'b1, 1'b0, `IBR_IDX_MAX_RATE, 1'b0, 32'h0beb_c200);
      acc(1'b1, 1'b0, `IBR_IDX_MEM_BYTES, 1'b0, 32'h0400_0000);
      // software side: a two-byte-per-sample board holds half as many samples as bytes
      chk(param_rdata_o >> 1, 32'h0200_0000);
      acc(1'b1, 1'b0, `IBR_IDX_OPTIONS, 1'b0, OPT_ALL);
      acc(1'b1, 1'b0, `IBR_IDX_IRQ_LINE, 1'b0, 32'h0000_0009);
      acc(1'b1, 1'b0, 16'h07d1, 1'b1, 32'h0000_0000);
   endtask : t_read_all
   task automatic t_write_refused();
      logic [15:0] idx [9];
      idx = '{`IBR_IDX_BOARD_TYPE, `IBR_IDX_HW_REV, `IBR_IDX_EXP_REV, `IBR_IDX_PROD_DATE, `IBR_IDX_SERIAL,
         `IBR_IDX_MAX_RATE, `IBR_IDX_MEM_BYTES, `IBR_IDX_OPTIONS, `IBR_IDX_IRQ_LINE};
      // every register refuses a write, also a write that comes with a read
      foreach (idx[i]) begin
         acc(1'b0, 1'b1, idx[i], 1'b1, 32'h0000_0000);
      end
      acc(1'b1, 1'b1, `IBR_IDX_SERIAL, 1'b1, 32'h0000_0000);
      acc(1'b1, 1'b0, `IBR_IDX_SERIAL, 1'b0, 32'h0001_2345);
      acc(1'b1, 1'b0, `IBR_IDX_OPTIONS, 1'b0, OPT_ALL);
   endtask : t_write_refused
   task automatic t_bad_images();
      rom_img[`IBR_SLOT_TYPE] = 32'h0000_1234;
      run_init(`IBR_ERR_BAD_TYPE);
      acc(1'b1, 1'b0, `IBR_IDX_SERIAL, 1'b1, 32'h0000_0000);
      rom_img[`IBR_SLOT_TYPE] = CODE_B;
      rom_img[`IBR_SLOT_OPTIONS] = `IBR_OPT_HUB_MODULE;
      run_init(`IBR_ERR_HUB_NO_SYNC);
      rom_img[`IBR_SLOT_OPTIONS] = `IBR_OPT_HUB_MODULE | `IBR_OPT_SYNCHRONIZATION;
      run_init(`IBR_ERR_OK);
      acc(1'b1, 1'b0, `IBR_IDX_BOARD_TYPE, 1'b0, CODE_B);
      acc(1'b1, 1'b0, `IBR_IDX_OPTIONS, 1'b0, 32'h0000_0a00);
   endtask : t_bad_images
   // the line follows a reassignment, so it is not a copy frozen at load time
   task automatic t_irq();
      @(posedge core_clk_i);
      irq_line_i <= 8'h0b;
      acc(1'b1, 1'b0, `IBR_IDX_IRQ_LINE, 1'b0, 32'h0000_000b);
      @(posedge core_clk_i);
      irq_line_i <= 8'hf4;
      acc(1'b1, 1'b0, `IBR_IDX_IRQ_LINE, 1'b0, 32'h0000_00f4);
   endtask : t_irq
   ////////////////////////////////////////////////////////////////////////////
   // clock, 100 MHz
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge core_clk_i);
      fail_count++;
      print_verdict();
   end
   // main sequence
   initial begin
      rst_i = 1'b1;
      init_req_i = 1'b0;
      param_rd_i = 1'b0;
      param_wr_i = 1'b0;
      param_idx_i = 16'h0000;
      rom_data_i = 32'h0000_0000;
      irq_line_i = 8'h09;
      fail_count = 0;
      checks_done = 0;
      rom_img = '{CODE_A, 32'h0000_3c5a, 32'h0000_0007, 32'h07e2_ab05, 32'h0001_2345, 32'h0beb_c200,
         32'h0400_0000, 32'hffff_ffff};
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_read_all();
      t_write_refused();
      t_bad_images();
      t_irq();
      print_verdict();
   end
endmodule : tb_top
